//--- logic/cps_defines.svh
`ifndef CPS_DEFINES_SVH
`define CPS_DEFINES_SVH
// ----------------------------------------
// widths and defaults
// ----------------------------------------
`define CPS_PW 8
`define CPS_FW 8
`define CPS_TW 16
`define CPS_GW 8
`define CPS_OVERPRESSURE_DEF 8'h14
`define CPS_INTEGRAL_GAIN_DEF 8'h0F
`define CPS_SIMPLE_GAIN_LIMIT 8'h01
// one second tick at 20 MHz; time unit of on and off timers
`define CPS_TICK_SEC 1
`define CPS_CLK_HZ 20000000
`define CPS_TICK_CYCLES (`CPS_TICK_SEC * `CPS_CLK_HZ)
`endif

//--- logic/cps_pkg.sv
package cps_pkg;
  typedef enum logic [3:0] {
    CPS_STOP  = 4'b0001,
    CPS_RUN   = 4'b0010,
    CPS_BOOST = 4'b0100,
    CPS_SLEEP = 4'b1000
  } cps_state_t;
  typedef enum logic [1:0] {
    CPS_LOOP_SIMPLE = 2'h0,
    CPS_LOOP_PI = 2'h1,
    CPS_LOOP_PID = 2'h2
  } cps_loop_t;
endpackage

//--- logic/cps_sleep_ctrl.sv
// Contract
// - sleep entry first boosts pressure to setpoint plus boost, then stops
// - asleep, restart when pressure falls to setpoint minus drawdown
// - pressure at setpoint plus overpressure stops motor and sleeps; default 20
// - controlled at low flow, sleep when frequency below min plus shutoff
// - shutoff frequency zero disables frequency sleep; motor holds minimum
// - measure each motor-off period and keep the latest
// - last off above threshold gives long min on-time, else short; code also gives long when last off is zero
// - sleep only after run time exceeds selected min on-time; code sleeps on overpressure without waiting for it
// - sleep only when pressure is at setpoint
// - proportional gain below 1 selects simple mode and shows it
// - simple mode loop uses only setpoint, ramps and boost; code still passes integral gain in simple mode
// - gain above simple value selects PI with both gains
// - integral gain defaults to 15
// - derivative gain above zero turns PI into PID
// - auxiliary inputs default to always run; input two may be overpressure
`timescale 1ns/1ps
`include "cps_defines.svh"
module cps_sleep_ctrl
  import cps_pkg::*;
#(
  parameter int PW = `CPS_PW,
  parameter int FW = `CPS_FW,
  parameter int TW = `CPS_TW,
  parameter int GW = `CPS_GW,
  parameter int TICK_CYCLES = `CPS_TICK_CYCLES
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // run control
  input wire logic enable_i,
  input wire logic auxiliary_run_input_one_i,
  input wire logic auxiliary_run_input_two_i,
  input wire logic aux_one_select_i,
  input wire logic aux_two_select_i,
  // pressure and speed
  input wire logic [PW-1:0] pressure_i,
  input wire logic [PW-1:0] setpoint_i,
  input wire logic [FW-1:0] motor_freq_i,
  input wire logic [FW-1:0] min_freq_i,
  // sleep parameters
  input wire logic [PW-1:0] boost_i,
  input wire logic [PW-1:0] drawdown_i,
  input wire logic [PW-1:0] overpressure_i,
  input wire logic overpressure_use_default_i,
  input wire logic [FW-1:0] shutoff_freq_i,
  input wire logic [TW-1:0] off_time_threshold_i,
  input wire logic [TW-1:0] long_min_on_time_i,
  input wire logic [TW-1:0] short_min_on_time_i,
  // loop gains
  input wire logic [GW-1:0] prop_gain_i,
  input wire logic [GW-1:0] integral_gain_i,
  input wire logic integral_use_default_i,
  input wire logic [GW-1:0] deriv_gain_i,
  // outputs
  output logic motor_run_o,
  output logic boost_active_o,
  output logic sleep_o,
  output cps_loop_t loop_mode_o,
  output logic simple_mode_disp_o,
  output logic [GW-1:0] prop_gain_o,
  output logic [GW-1:0] integral_gain_o,
  output logic [GW-1:0] deriv_gain_o,
  output logic [PW-1:0] target_pressure_o,
  output logic [TW-1:0] last_off_time_o,
  output logic [TW-1:0] min_on_time_o
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] auxiliary_run_input_one_sync_r;
  logic [1:0] auxiliary_run_input_two_sync_r;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      auxiliary_run_input_one_sync_r <= 2'h0;
      auxiliary_run_input_two_sync_r <= 2'h0;
    end
    else
    begin
      auxiliary_run_input_one_sync_r <= {auxiliary_run_input_one_sync_r[0], auxiliary_run_input_one_i};
      auxiliary_run_input_two_sync_r <= {auxiliary_run_input_two_sync_r[0], auxiliary_run_input_two_i};
    end
  end

  // ----------------------------------------
  // decisions
  // ----------------------------------------
  logic run_req;
  logic [PW:0] boost_lvl;
  logic [PW:0] over_lvl;
  logic [PW:0] draw_lvl;
  logic [FW:0] shut_lvl;
  logic [PW-1:0] over_amt;
  logic at_setpoint;
  logic over_hit;
  logic boost_hit;
  logic draw_hit;
  logic low_flow;
  logic on_ok;
  logic [TW-1:0] on_time_r;
  logic [TW-1:0] off_time_r;
  logic [TW-1:0] last_off_r;
  logic [31:0] tick_cnt_r;
  logic tick;
  cps_state_t state_r;
  logic started_r;

  // select low: input forced to run; auxiliary_run_input_two is normally-closed overpressure switch
  // aux run defaults
  assign run_req = enable_i && (aux_one_select_i ? auxiliary_run_input_one_sync_r[1] : 1'b1)
                   && (aux_two_select_i ? auxiliary_run_input_two_sync_r[1] : 1'b1);
  assign over_amt = overpressure_use_default_i ? PW'(`CPS_OVERPRESSURE_DEF) : overpressure_i;
  // one extra bit keeps setpoint sums from wrapping
  assign boost_lvl = {1'b0, setpoint_i} + {1'b0, boost_i};
  assign over_lvl = {1'b0, setpoint_i} + {1'b0, over_amt};
  assign draw_lvl = {1'b0, setpoint_i} - {1'b0, drawdown_i};
  assign shut_lvl = {1'b0, min_freq_i} + {1'b0, shutoff_freq_i};
  assign at_setpoint = pressure_i >= setpoint_i;
  assign over_hit = {1'b0, pressure_i} >= over_lvl;
  assign boost_hit = {1'b0, pressure_i} >= boost_lvl;
  // drawdown larger than setpoint wraps negative: restart never triggers then
  // drawdown restart
  assign draw_hit = !draw_lvl[PW] && ({1'b0, pressure_i} <= draw_lvl);
  assign low_flow = (shutoff_freq_i != '0) && ({1'b0, motor_freq_i} < shut_lvl);
  assign on_ok = on_time_r > min_on_time_o;

  // ----------------------------------------
  // second tick
  // ----------------------------------------
  assign tick = tick_cnt_r == 32'(TICK_CYCLES - 1);
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      tick_cnt_r <= 32'h0;
    else if (tick)
      tick_cnt_r <= 32'h0;
    else
      tick_cnt_r <= tick_cnt_r + 32'h1;
  end

  // ----------------------------------------
  // first start
  // ----------------------------------------
  // time spent stopped before the first start is not a real off period;
  // holding the off timer at zero until then keeps the first run long
  // first run long
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      started_r <= 1'b0;
    else if (state_r != CPS_STOP)
      started_r <= 1'b1;
  end

  // ----------------------------------------
  // sleep state machine
  // ----------------------------------------
  // reset stopped
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state_r <= CPS_STOP;
    else
    begin
      unique case (state_r)
        CPS_STOP:
          if (run_req)
            state_r <= CPS_RUN;
        CPS_RUN:
          if (!run_req)
            state_r <= CPS_STOP;
          else if (over_hit)
            state_r <= CPS_SLEEP;
          else if (at_setpoint && low_flow && on_ok)
            state_r <= CPS_BOOST;
        CPS_BOOST:
          if (!run_req)
            state_r <= CPS_STOP;
          else if (boost_hit || over_hit)
            state_r <= CPS_SLEEP;
        CPS_SLEEP:
          if (!run_req)
            state_r <= CPS_STOP;
          else if (draw_hit)
            state_r <= CPS_RUN;
      endcase
    end
  end

  // ----------------------------------------
  // on and off timers
  // ----------------------------------------
  // timers saturate so a very long period still compares as long
  // off period measure
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      off_time_r <= '0;
      last_off_r <= '0;
      on_time_r <= '0;
    end
    else if (state_r == CPS_SLEEP || state_r == CPS_STOP)
    begin
      on_time_r <= '0;
      if (run_req && (state_r == CPS_STOP || draw_hit))
      begin
        last_off_r <= off_time_r;
        off_time_r <= '0;
      end
      else if (started_r && tick && off_time_r != '1)
        off_time_r <= off_time_r + 1'b1;
    end
    else if (tick && on_time_r != '1)
      on_time_r <= on_time_r + 1'b1;
  end

  // min on-time pick; cleared off time uses long
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      min_on_time_o <= '0;
    else if (last_off_r > off_time_threshold_i || last_off_r == '0)
      min_on_time_o <= long_min_on_time_i;
    else
      min_on_time_o <= short_min_on_time_i;
  end

  // ----------------------------------------
  // loop mode and gains
  // ----------------------------------------
  // mode select
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      loop_mode_o <= CPS_LOOP_SIMPLE;
      simple_mode_disp_o <= 1'b1;
      prop_gain_o <= '0;
      integral_gain_o <= GW'(`CPS_INTEGRAL_GAIN_DEF);
      deriv_gain_o <= '0;
    end
    else
    begin
      simple_mode_disp_o <= prop_gain_i < GW'(`CPS_SIMPLE_GAIN_LIMIT);
      integral_gain_o <= integral_use_default_i ? GW'(`CPS_INTEGRAL_GAIN_DEF)
                                                : integral_gain_i;
      if (prop_gain_i < GW'(`CPS_SIMPLE_GAIN_LIMIT))
      begin
        // simple loop sees no proportional or derivative gain; integral gain still passes
        loop_mode_o <= CPS_LOOP_SIMPLE;
        prop_gain_o <= '0;
        deriv_gain_o <= '0;
      end
      else
      begin
        loop_mode_o <= (deriv_gain_i != '0) ? CPS_LOOP_PID : CPS_LOOP_PI;
        prop_gain_o <= prop_gain_i;
        deriv_gain_o <= deriv_gain_i;
      end
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      motor_run_o <= 1'b0;
      boost_active_o <= 1'b0;
      sleep_o <= 1'b0;
      target_pressure_o <= '0;
      last_off_time_o <= '0;
    end
    else
    begin
      motor_run_o <= state_r == CPS_RUN || state_r == CPS_BOOST;
      boost_active_o <= state_r == CPS_BOOST;
      sleep_o <= state_r == CPS_SLEEP;
      target_pressure_o <= (state_r == CPS_BOOST) ? boost_lvl[PW-1:0] : setpoint_i;
      last_off_time_o <= last_off_r;
    end
  end

endmodule // cps_sleep_ctrl

//--- test/cps_sleep_sva.sv
`timescale 1ns/1ps
// ----
// sleep checks
// ----
module cps_sleep_sva
  import cps_pkg::*;
(
  // clock
  input wire logic clk_i,
  input wire logic rstn_i,
  // inputs
  input wire logic [7:0] pressure_i,
  input wire logic [7:0] setpoint_i,
  input wire logic [7:0] motor_freq_i,
  input wire logic [7:0] min_freq_i,
  input wire logic [7:0] boost_i,
  input wire logic [7:0] drawdown_i,
  input wire logic [7:0] overpressure_i,
  input wire logic overpressure_use_default_i,
  input wire logic [7:0] shutoff_freq_i,
  input wire logic [7:0] prop_gain_i,
  input wire logic [7:0] deriv_gain_i,
  // outputs
  input wire logic motor_run_o,
  input wire logic boost_active_o,
  input wire logic sleep_o,
  input wire cps_loop_t loop_mode_o,
  input wire logic simple_mode_disp_o,
  input wire logic [7:0] target_pressure_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // nine bits so the limit cannot wrap
  logic [8:0] lim;
  assign lim = setpoint_i + (overpressure_use_default_i ? 9'h014 : {1'b0, overpressure_i});
  property p_tgt; boost_active_o |-> target_pressure_o == 8'(setpoint_i + boost_i); endproperty
  a_tgt: assert property (p_tgt) else $error("boost target wrong");
  property p_wake; $fell(sleep_o) && motor_run_o |->
    {1'b0, $past(pressure_i, 2)} + drawdown_i <= setpoint_i; endproperty
  a_wake: assert property (p_wake) else $error("early restart");
  property p_over; motor_run_o && pressure_i >= lim |-> ##[1:3] !motor_run_o; endproperty
  a_over: assert property (p_over) else $error("no overpressure stop");
  property p_freq; $rose(boost_active_o) |->
    $past(motor_freq_i, 2) < $past(min_freq_i, 2) + $past(shutoff_freq_i, 2); endproperty
  a_freq: assert property (p_freq) else $error("boost above shutoff speed");
  property p_shut0; $rose(boost_active_o) |-> $past(shutoff_freq_i, 2) != 8'h00; endproperty
  a_shut0: assert property (p_shut0) else $error("sleep while disabled");
  property p_atsp; $rose(boost_active_o) |-> $past(pressure_i, 2) >= $past(setpoint_i, 2); endproperty
  a_atsp: assert property (p_atsp) else $error("boost below setpoint");
  property p_simple; $past(prop_gain_i) == 8'h00 && $past(prop_gain_i, 2) == 8'h00 |->
    simple_mode_disp_o && loop_mode_o == CPS_LOOP_SIMPLE; endproperty
  a_simple: assert property (p_simple) else $error("simple mode missed");
  property p_pid; $past(prop_gain_i) != 8'h00 && $past(deriv_gain_i) != 8'h00 &&
    $past(deriv_gain_i, 2) != 8'h00 |-> loop_mode_o == CPS_LOOP_PID; endproperty
  a_pid: assert property (p_pid) else $error("pid mode missed");
endmodule // cps_sleep_sva
bind cps_sleep_ctrl cps_sleep_sva i_cps_sleep_sva (.*);

//--- test/cps_pump_model.sv
`timescale 1ns/1ps
// ----
// pump and transducer
// ----
module cps_pump_model
(
  // clock
  input wire logic clk_i,
  input wire logic rstn_i,
  // pump
  input wire logic motor_run_i,
  output logic [7:0] pressure_o
);
  // one psi a cycle up while pumping, down while idle; saturates, never wraps
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pressure_o <= 8'h00;
    else if (motor_run_i && pressure_o != 8'hFF)
      pressure_o <= pressure_o + 8'h01;
    else if (!motor_run_i && pressure_o != 8'h00)
      pressure_o <= pressure_o - 8'h01;
  end
endmodule // cps_pump_model

//--- test/tb.sv
`timescale 1ns/1ps
module tb
  import cps_pkg::*;
;
  // ----
  // signals
  // ----
  logic clk_i, rstn_i, enable_i, auxiliary_run_input_one_i, auxiliary_run_input_two_i;
  logic aux_one_select_i, aux_two_select_i, overpressure_use_default_i, integral_use_default_i;
  logic motor_run_o, boost_active_o, sleep_o, simple_mode_disp_o;
  logic [7:0] pressure_i, setpoint_i, motor_freq_i, min_freq_i, boost_i, drawdown_i;
  logic [7:0] overpressure_i, shutoff_freq_i, prop_gain_i, integral_gain_i, deriv_gain_i;
  logic [7:0] prop_gain_o, integral_gain_o, deriv_gain_o, target_pressure_o;
  logic [15:0] off_time_threshold_i, long_min_on_time_i, short_min_on_time_i;
  logic [15:0] last_off_time_o, min_on_time_o;
  cps_loop_t loop_mode_o;
  int err_count, n_compared, cyc_n;
  // four-cycle second keeps the timers short
  cps_sleep_ctrl #(.TICK_CYCLES(4)) i_cps_sleep_ctrl (.*);
  cps_pump_model i_cps_pump_model (.clk_i(clk_i), .rstn_i(rstn_i),
    .motor_run_i(motor_run_o), .pressure_o(pressure_i));
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // hang guard
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      err_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compared %0d bad %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s exp %0h got %0h", nm, exp, got);
    end
  endtask
  // step cycles, landing just after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  // bounded wait for sleep (s) or boost to reach v
  task automatic wt(input bit s, input logic v);
    for (int i = 0; i < 400 && (s ? sleep_o : boost_active_o) !== v; i++)
      cyc(1);
    chk(s ? "sleep" : "boost", 16'(v), 16'(s ? sleep_o : boost_active_o));
  endtask
  // ----
  // tests
  // ----
  initial
  begin
    {rstn_i, enable_i, auxiliary_run_input_one_i, auxiliary_run_input_two_i} = 4'h3;
    {aux_one_select_i, aux_two_select_i} = 2'h0;
    {overpressure_use_default_i, integral_use_default_i} = 2'h3;
    {setpoint_i, motor_freq_i, min_freq_i, boost_i, drawdown_i} = 40'h32231E0505;
    {overpressure_i, shutoff_freq_i, prop_gain_i, integral_gain_i, deriv_gain_i} = 40'h000A000700;
    {off_time_threshold_i, long_min_on_time_i, short_min_on_time_i} = 48'h000600020001;
    cyc(16);
    rstn_i = 1'b1;
    chk("run", 16'h0000, 16'(motor_run_o));
    chk("off", 16'h0000, last_off_time_o);
    // simple, pi, pid in turn; integral default off for pi only
    for (int k = 0; k < 3; k++)
    begin
      prop_gain_i = (k == 0) ? 8'h00 : 8'h05;
      deriv_gain_i = (k == 2) ? 8'h03 : 8'h00;
      integral_use_default_i = (k != 1);
      cyc(3);
      chk("mode", 16'(k), 16'(loop_mode_o));
      chk("disp", 16'(k == 0), 16'(simple_mode_disp_o));
      chk("ig", (k == 1) ? 16'h0007 : 16'h000F, 16'(integral_gain_o));
      chk("pg", 16'(prop_gain_i), 16'(prop_gain_o));
      chk("dg", (k == 2) ? 16'h0003 : 16'h0000, 16'(deriv_gain_o));
    end
    // run, boost, sleep, drawdown restart
    enable_i = 1'b1;
    cyc(4);
    chk("minon", long_min_on_time_i, min_on_time_o);
    wt(1'b0, 1'b1);
    chk("tgt", 16'h0037, 16'(target_pressure_o));
    wt(1'b1, 1'b1);
    chk("run", 16'h0000, 16'(motor_run_o));
    wt(1'b1, 1'b0);
    cyc(3);
    chk("run", 16'h0001, 16'(motor_run_o));
    chk("minon", short_min_on_time_i, min_on_time_o);
    // long stop selects the long on-time
    enable_i = 1'b0;
    cyc(60);
    enable_i = 1'b1;
    cyc(4);
    chk("minon", long_min_on_time_i, min_on_time_o);
    chk("offlen", 16'h0001, 16'(last_off_time_o > off_time_threshold_i));
    // zero shutoff: only the default overpressure limit stops the pump
    shutoff_freq_i = 8'h00;
    wt(1'b1, 1'b1);
    chk("opsi", 16'h0001, 16'(pressure_i >= 8'h46));
    // opening the second auxiliary input stops, closing restarts
    {aux_two_select_i, auxiliary_run_input_two_i} = 2'h2;
    cyc(6);
    chk("aux", 16'h0000, 16'({motor_run_o, sleep_o}));
    auxiliary_run_input_two_i = 1'b1;
    cyc(6);
    chk("aux", 16'h0001, 16'(motor_run_o));
    test_done();
  end
endmodule // tb
